//--- verilog/timer_route_pkg.sv
// Constants for the timer pin routing and raw interrupt status block.
// Assumes a plain register port with one-cycle read latency.
// How it works
// [R1] A pin whose route-select bit is 0 is left to general-purpose I/O and the timer does not drive it.
// [R2] A pin whose route-select bit is 1 is driven by the timer match output, which follows the channel PWM-enable bit.
// [R3] Route-select bits for pins 0 to 14 sit at bits 0 to 14, are read/write, and reset to 0.
// [R4] A read-only raw status register at 0xA4 shows each interrupt condition whether enabled or not.
// [R5] An interrupt goes to the interrupt controller only when a raw flag and its enable bit are both set.
// [R6] The capture-channel-0 flag at bit 25 is set when the capture 0 condition occurs and resets to 0.
// [R7] The match-channel-0 flag at bit 0 is set when the match 0 condition occurs and resets to 0.
// [R8] Raw status bits 31 to 26 and 24 to 1 are reserved and read as zero.
// [R9] With PWM-enable 0 a match output follows external-match control; with 1 it carries the PWM waveform.
// [R10] The route-select bits live in a register at 0xA0; each match output is chosen independently.
// [R11] A raw flag sets in the cycle its event is seen and stays set until software clears it.
package timer_route_pkg;
   // ==========================================================
   // Widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NUM_PINS = 15;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_ROUTE_SEL = 8'hA0;
   localparam logic [7:0] OFS_RAW_STATUS = 8'hA4;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'hA8;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'hAC;
   localparam logic [7:0] OFS_PWM_ON = 8'hB0;
   localparam logic [7:0] OFS_EXT_MATCH = 8'hB4;
   // ==========================================================
   // Field positions
   localparam int unsigned BIT_MATCH0 = 0;
   localparam int unsigned BIT_CAPTURE0 = 25;
   localparam logic [31:0] STATUS_MASK = 32'h0200_0001;
   // ==========================================================
   // Reset values
   localparam logic [14:0] ROUTE_RST = 15'h0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

//--- verilog/sticky_flag.sv
// One sticky event flag with write-one-to-clear.
// Assumes event and clear are single-cycle pulses in the core clock domain.
`timescale 1ns/100ps
module sticky_flag (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_event,
   input wire logic i_clear,
   output logic o_flag
);
   // ==========================================================
   // Flag storage
   // Set wins over clear so an event in the clear cycle is kept
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_flag <= 1'b0;
      end else if (i_event) begin
         o_flag <= 1'b1; // [R11]
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end
endmodule

//--- verilog/pin_route_mux.sv
// Output mux for one timer pin: route select and PWM/external-match choice.
// Assumes the GPIO block drives the pin whenever o_oe is low.
`timescale 1ns/100ps
module pin_route_mux (
   input wire logic i_route_sel,
   input wire logic i_pwm_on,
   input wire logic i_pwm_wave,
   input wire logic i_ext_match,
   output logic o_level,
   output logic o_oe
);
   // ==========================================================
   // Source selection
   assign o_level = i_route_sel ? (i_pwm_on ? i_pwm_wave : i_ext_match) : 1'b0; // [R2] [R9]
   // Released to GPIO when not selected
   assign o_oe = i_route_sel; // [R1] [R2]
endmodule

//--- verilog/timer_pin_route_irq_status.sv
// Timer pin routing and raw interrupt status, register slave and interrupt.
// Assumes strobes are one cycle, never together, synchronous to i_core_clk.
`timescale 1ns/100ps
module timer_pin_route_irq_status (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_match0_event,
   input wire logic i_capture0_event,
   input wire logic [14:0] i_pwm_wave,
   output logic [14:0] o_pin_level,
   output logic [14:0] o_pin_oe,
   output logic o_irq
);
   // ==========================================================
   // Declarations
   logic [14:0] route_sel;
   logic [14:0] pwm_on;
   logic [14:0] ext_match;
   logic [31:0] irq_enable;
   logic match0_flag;
   logic capture0_flag;
   logic [31:0] raw_status;
   logic clear_match0;
   logic clear_capture0;
   logic wr_clear;
   logic [31:0] next_rdata;

   // ==========================================================
   // Write decode
   assign wr_clear = i_wr && (i_addr == timer_route_pkg::OFS_IRQ_CLEAR);
   assign clear_match0 = wr_clear && i_wdata[timer_route_pkg::BIT_MATCH0];
   assign clear_capture0 = wr_clear && i_wdata[timer_route_pkg::BIT_CAPTURE0];

   // Route select register, pins start as GPIO
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         route_sel <= timer_route_pkg::ROUTE_RST; // [R3]
      end else if (i_wr && (i_addr == timer_route_pkg::OFS_ROUTE_SEL)) begin
         route_sel <= i_wdata[14:0]; // [R3] [R10]
      end
   end

   // PWM enable and external-match control, per channel
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pwm_on <= timer_route_pkg::ROUTE_RST;
         ext_match <= timer_route_pkg::ROUTE_RST;
      end else if (i_wr && (i_addr == timer_route_pkg::OFS_PWM_ON)) begin
         pwm_on <= i_wdata[14:0]; // [R9]
      end else if (i_wr && (i_addr == timer_route_pkg::OFS_EXT_MATCH)) begin
         ext_match <= i_wdata[14:0]; // [R9]
      end
   end

   // Interrupt enable, only implemented bits kept
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_enable <= timer_route_pkg::WORD_RST;
      end else if (i_wr && (i_addr == timer_route_pkg::OFS_IRQ_ENABLE)) begin
         irq_enable <= i_wdata & timer_route_pkg::STATUS_MASK;
      end
   end

   // ==========================================================
   // Raw flags
   sticky_flag u_match0 (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_event(i_match0_event),
      .i_clear(clear_match0),
      .o_flag(match0_flag)
   );

   sticky_flag u_capture0 (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_event(i_capture0_event),
      .i_clear(clear_capture0),
      .o_flag(capture0_flag)
   );

   // Reserved bits tied low
   always_comb begin
      raw_status = timer_route_pkg::WORD_RST; // [R8]
      raw_status[timer_route_pkg::BIT_MATCH0] = match0_flag; // [R7]
      raw_status[timer_route_pkg::BIT_CAPTURE0] = capture0_flag; // [R6]
   end

   // Raw status ignores enables; the output does not
   assign o_irq = |(raw_status & irq_enable); // [R5] [R4]

   // ==========================================================
   // Pin routing
   genvar g;
   generate
      for (g = 0; g < 15; g = g + 1) begin : g_pin
         pin_route_mux u_mux (
            .i_route_sel(route_sel[g]),
            .i_pwm_on(pwm_on[g]),
            .i_pwm_wave(i_pwm_wave[g]),
            .i_ext_match(ext_match[g]),
            .o_level(o_pin_level[g]),
            .o_oe(o_pin_oe[g])
         );
      end
   endgenerate

   // ==========================================================
   // Read path, unmapped reads give zero
   always_comb begin
      next_rdata = timer_route_pkg::WORD_RST;
      unique case (i_addr)
         timer_route_pkg::OFS_ROUTE_SEL: next_rdata = {17'h0, route_sel};
         timer_route_pkg::OFS_RAW_STATUS: next_rdata = raw_status; // [R4]
         timer_route_pkg::OFS_IRQ_ENABLE: next_rdata = irq_enable;
         timer_route_pkg::OFS_PWM_ON: next_rdata = {17'h0, pwm_on};
         timer_route_pkg::OFS_EXT_MATCH: next_rdata = {17'h0, ext_match};
         default: next_rdata = timer_route_pkg::WORD_RST;
      endcase
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= timer_route_pkg::WORD_RST;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= timer_route_pkg::WORD_RST;
      end
   end
endmodule

//--- dv/gpio_pin_model.sv
// GPIO side of the timer pins: resolves each pin wire.
// Assumes the timer drives a pin only while its enable is high.
`timescale 1ns/100ps
module gpio_pin_model (
   input wire logic i_core_clk,
   input wire logic [14:0] i_level,
   input wire logic [14:0] i_oe,
   output logic [14:0] o_pin
);
   logic [14:0] gpio_drive = 15'h2AAA;
   // Released pins flip every cycle, so a stale level never passes
   always @(posedge i_core_clk) gpio_drive <= ~gpio_drive;
   assign o_pin = (i_oe & i_level) | (~i_oe & gpio_drive);
endmodule

//--- dv/timer_pin_route_irq_status_chk.sv
// Port checker for the pin routing and raw status block.
// Bound to the top module; sees its ports only.
`timescale 1ns/100ps
module timer_pin_route_irq_status_chk (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic i_match0_event,
   input wire logic i_capture0_event,
   input wire logic [14:0] i_pwm_wave,
   input wire logic [14:0] o_pin_level,
   input wire logic [14:0] o_pin_oe,
   input wire logic o_irq
);
   // ==========================================================
   // Properties
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);
   property p_rel; (o_pin_level & ~o_pin_oe) == 15'h0000; endproperty
   a_rel: assert property (p_rel) else $error("released pin driven");
   property p_idle; !i_rd |=> o_rdata == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_rsv; i_rd && i_addr == 8'hA4 |=> (o_rdata & 32'hFDFF_FFFE) == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   // An event beside a clear must leave the flag set
   property p_setwin;
      i_match0_event && i_wr && i_addr == 8'hAC && i_wdata[0] ##1 (i_rd && i_addr == 8'hA4)
      |=> o_rdata[0];
   endproperty
   a_setwin: assert property (p_setwin) else $error("clear beat event");
   property p_m0; i_match0_event ##1 !i_wr ##1 (i_rd && i_addr == 8'hA4) |=> o_rdata[0];
   endproperty
   a_m0: assert property (p_m0) else $error("match flag lost");
   property p_c0; i_capture0_event ##1 !i_wr ##1 (i_rd && i_addr == 8'hA4) |=> o_rdata[25];
   endproperty
   a_c0: assert property (p_c0) else $error("capture flag lost");
   property p_route; i_wr && i_addr == 8'hA0 |=> o_pin_oe == $past(i_wdata[14:0]); endproperty
   a_route: assert property (p_route) else $error("route write");
   property p_keep; !(i_wr && i_addr == 8'hA0) |=> $stable(o_pin_oe); endproperty
   a_keep: assert property (p_keep) else $error("route changed");
   property p_irq; $rose(o_irq) |-> $past(i_match0_event || i_capture0_event || i_wr);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");
   cover property (i_rd && i_addr == 8'hA4);
   cover property ($rose(o_irq));
   cover property (o_pin_oe == 15'h7FFF);
   cover property (i_match0_event && i_wr && i_addr == 8'hAC);
endmodule

//--- dv/timer_pin_route_irq_status_bench.sv
// Bench: register tasks, event pulses and pin checks.
// Assumes the GPIO model resolves the pin wires.
`timescale 1ns/100ps
module timer_pin_route_irq_status_bench;
   logic i_core_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, ev_m = 0, ev_c = 0, o_irq;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
   logic [14:0] wave = 15'h0F0F, o_pin_level, o_pin_oe, pin;
   int num_errors = 0, checked = 0, cycles = 0;
   timer_pin_route_irq_status i_timer_pin_route_irq_status (.i_core_clk, .i_reset_n,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_match0_event(ev_m),
      .i_capture0_event(ev_c), .i_pwm_wave(wave), .o_pin_level, .o_pin_oe, .o_irq);
   gpio_pin_model i_gpio_pin_model (.i_core_clk, .i_level(o_pin_level), .i_oe(o_pin_oe),
      .o_pin(pin));
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
      @(posedge i_core_clk) i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_core_clk) {i_addr, i_rd} <= {a, 1'b1};
      @(posedge i_core_clk) i_rd <= 1'b0;
      #1 chk(o_rdata, e);
   endtask
   // Pin checks look at the resolved wire too, not only the ports
   task automatic pins(input logic [14:0] r, input logic [14:0] e);
      #1 chk({17'h0, o_pin_oe}, {17'h0, r});
      chk({17'h0, o_pin_level}, {17'h0, e});
      chk({17'h0, pin & r}, {17'h0, e});
   endtask
   task automatic pulse(input logic m, input logic c);
      @(posedge i_core_clk) {ev_m, ev_c} <= {m, c};
      @(posedge i_core_clk) {ev_m, ev_c} <= 2'b00;
   endtask
   task automatic give_verdict();
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Clock and hang guard; the run needs well under 200 cycles
   initial forever #5 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      rd(8'hA0, 32'h0000_0000);
      rd(8'hA4, 32'h0000_0000);
      pins(15'h0000, 15'h0000);
      wr(8'hB0, 32'h0000_5555);
      wr(8'hB4, 32'h0000_3C3C);
      wr(8'hA0, 32'hFFFF_FFFF);
      pins(15'h7FFF, 15'h2D2D);
      rd(8'hA0, 32'h0000_7FFF);
      wr(8'hA0, 32'h0000_00F0);
      pins(15'h00F0, 15'h0020);
      wr(8'hA4, 32'hFFFF_FFFF);
      rd(8'hA4, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      pulse(1'b1, 1'b0);
      rd(8'hA4, 32'h0000_0001);
      chk({31'h0, o_irq}, 32'h0000_0000);
      wr(8'hA8, 32'hFFFF_FFFF);
      #1 chk({31'h0, o_irq}, 32'h0000_0001);
      pulse(1'b0, 1'b1);
      rd(8'hA4, 32'h0200_0001);
      wr(8'hAC, 32'h0000_0001);
      rd(8'hA4, 32'h0200_0000);
      wr(8'hA8, 32'h0000_0000);
      #1 chk({31'h0, o_irq}, 32'h0000_0000);
      // Event and clear in one cycle: the event must win
      @(posedge i_core_clk) {ev_m, i_addr, i_wdata, i_wr} <= {1'b1, 8'hAC, 32'h0000_0001, 1'b1};
      @(posedge i_core_clk) {ev_m, i_wr} <= 2'b00;
      rd(8'hA4, 32'h0200_0001);
      // Reset in mid-run brings raw status and route select back
      @(posedge i_core_clk) i_reset_n <= 1'b0;
      @(posedge i_core_clk) i_reset_n <= 1'b1;
      rd(8'hA4, 32'h0000_0000);
      rd(8'hA0, 32'h0000_0000);
      pins(15'h0000, 15'h0000);
      give_verdict();
   end
endmodule
bind timer_pin_route_irq_status timer_pin_route_irq_status_chk i_timer_pin_route_irq_status_chk (
   .i_core_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_match0_event,
   .i_capture0_event, .i_pwm_wave, .o_pin_level, .o_pin_oe, .o_irq);
